/* File: vip_pkg.sv */
// constants for the vectored interrupt prioritizer: register addresses,
// field positions, reset values, source ranks and vector addresses.
// assumes an 8-bit special-register space seen through a plain port.
`default_nettype none

package vip_pkg;

  // widths and counts
  localparam int NUM_SRC = 11;
  localparam int NUM_REG = 6;
  localparam int NUM_LVL = 4;

  // byte addresses of the registers
  localparam logic [7:0] ADDR_IRQ_ENABLE_BANK0    = 8'hA8;
  localparam logic [7:0] ADDR_PRIORITY_LOW_BANK0  = 8'hB8;
  localparam logic [7:0] ADDR_PRIORITY_HIGH_BANK0 = 8'hB7;
  localparam logic [7:0] ADDR_IRQ_ENABLE_BANK1    = 8'hE8;
  localparam logic [7:0] ADDR_PRIORITY_LOW_BANK1  = 8'hF8;
  localparam logic [7:0] ADDR_PRIORITY_HIGH_BANK1 = 8'hF7;
  localparam logic [7:0] ADDR_IN_SERVICE          = 8'hF9;

  // index of each register in the storage array
  localparam int IDX_IRQ_ENABLE_BANK0 = 0;
  localparam int IDX_PRIORITY_LOW_BANK0 = 1;
  localparam int IDX_PRIORITY_HIGH_BANK0 = 2;
  localparam int IDX_IRQ_ENABLE_BANK1 = 3;
  localparam int IDX_PRIORITY_LOW_BANK1 = 4;
  localparam int IDX_PRIORITY_HIGH_BANK1 = 5;

  typedef logic [7:0] vip_byte_t;
  localparam vip_byte_t REG_ADDR [NUM_REG] = '{
    ADDR_IRQ_ENABLE_BANK0, ADDR_PRIORITY_LOW_BANK0, ADDR_PRIORITY_HIGH_BANK0,
    ADDR_IRQ_ENABLE_BANK1, ADDR_PRIORITY_LOW_BANK1, ADDR_PRIORITY_HIGH_BANK1};

  // writable bits of each register; reserved bits stay zero
  localparam vip_byte_t REG_WMASK [NUM_REG] = '{
    8'hFF, 8'h7F, 8'h7F, 8'h0F, 8'h0F, 8'h0F};

  // registers that accept single-bit writes
  localparam logic [NUM_REG-1:0] REG_BIT_OK = 6'b01_1011;

  // reset value of every register
  localparam vip_byte_t REG_RESET = 8'h00;

  // field positions in bank 0 (enable, low and high priority alike)
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_PCA    = 6;
  localparam int BIT_TIMER2 = 5;
  localparam int BIT_SERIAL = 4;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_EXT1   = 2;
  localparam int BIT_TIMER0 = 1;
  localparam int BIT_EXT0   = 0;

  // field positions in bank 1
  localparam int BIT_SPI     = 3;
  localparam int BIT_OVERRUN = 2;
  localparam int BIT_ADC     = 1;
  localparam int BIT_CAN     = 0;

  // source index equals polling rank minus one
  localparam int SRC_EXT0    = 0;
  localparam int SRC_TIMER0  = 1;
  localparam int SRC_EXT1    = 2;
  localparam int SRC_TIMER1  = 3;
  localparam int SRC_PCA     = 4;
  localparam int SRC_SERIAL  = 5;
  localparam int SRC_TIMER2  = 6;
  localparam int SRC_CAN     = 7;
  localparam int SRC_ADC     = 8;
  localparam int SRC_OVERRUN = 9;
  localparam int SRC_SPI     = 10;

  // vector address per source, in rank order
  typedef logic [15:0] vip_vec_t;
  localparam vip_vec_t SRC_VECTOR [NUM_SRC] = '{
    16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0033, 16'h0023,
    16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053};

endpackage

`default_nettype wire

/* File: vip_reg_if.sv */
// bundle between the prioritizer and one of its register bytes.
// assumes one write source per byte, decoded by the prioritizer.
`timescale 1ns/1ps
`default_nettype none

interface vip_reg_if;
  logic       wr_byte;
  logic       bit_wr;
  logic [2:0] bit_idx;
  logic       bit_val;
  logic [7:0] wdata;
  logic [7:0] q;

  modport ctrl  (output wr_byte, bit_wr, bit_idx, bit_val, wdata, input q);
  modport store (input wr_byte, bit_wr, bit_idx, bit_val, wdata, output q);
endinterface

`default_nettype wire

/* File: vip_sfr_byte.sv */
// one 8-bit register with whole-byte and single-bit writes.
// assumes the strobes arrive already decoded and one cycle long.
`timescale 1ns/1ps
`default_nettype none

module vip_sfr_byte #(
  parameter logic [7:0] WMASK = 8'hFF
) (
  // clock and reset
  input wire logic    clk,
  input wire logic    rst,
  // register access
  vip_reg_if.store    rif
);

  logic [7:0] q_reg;

  // byte write replaces, bit write changes one position; reserved stay 0
  always_ff @(posedge clk) begin
    if (rst) begin
      q_reg <= vip_pkg::REG_RESET;
    end else if (rif.wr_byte) begin
      q_reg <= rif.wdata & WMASK;
    end else if (rif.bit_wr && WMASK[rif.bit_idx]) begin
      q_reg[rif.bit_idx] <= rif.bit_val;
    end
  end

  assign rif.q = q_reg;

endmodule

`default_nettype wire

/* File: vip_prioritizer.sv */
// vectored interrupt prioritizer: enables, four-level priority, polling
// order, vector output and nesting of handlers in service.
// assumes request inputs are levels held by their sources until serviced
// and that the core pulses irq_ack on taking a vector and irq_return on
// leaving a handler.
// a request that drops before the core takes it is simply withdrawn.
// stray acknowledge pulses while irq_req is low are ignored.
// a return with no handler in service has no effect.
// reserved register bits read as zero; software keeps them clear.
// the register port never waits; read data follow the strobe by a cycle.
// the levels in service read back at a status address.
// every output is a flip-flop; no input reaches an output directly.
`timescale 1ns/1ps
`default_nettype none

module vip_prioritizer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port, byte access
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // register port, single-bit write
  input  wire logic        bit_wr,
  input  wire logic [7:0]  bit_addr,
  input  wire logic        bit_wdata,
  // interrupt sources, active high levels
  input  wire logic        external_request_0,
  input  wire logic        external_request_1,
  // timer overflows
  input  wire logic        timer0_req,
  input  wire logic        timer1_req,
  input  wire logic        timer2_req,
  // serial port and PCA
  input  wire logic        serial_req,
  input  wire logic        pca_req,
  // CAN controller events and its timer overflow
  input  wire logic        can_tx_done,
  input  wire logic        can_rx_done,
  input  wire logic        can_error,
  input  wire logic        can_buf_overrun,
  input  wire logic        can_timer_overflow,
  // converter flag and SPI
  input  wire logic        conversion_done_flag,
  input  wire logic        spi_req,
  // processor core side
  output logic             irq_req,
  output logic      [15:0] irq_vector,
  output logic      [1:0]  irq_level,
  output logic      [3:0]  in_service,
  // from the core
  input  wire logic        irq_ack,
  input  wire logic        irq_return
);

  // short names for the package counts
  localparam int NS = vip_pkg::NUM_SRC;
  localparam int NR = vip_pkg::NUM_REG;

  // register storage and its read-back values
  vip_reg_if  rif [NR] ();
  logic [7:0] reg_q [NR];

  // register bytes by name
  logic [7:0] irq_enable_bank0;
  logic [7:0] irq_enable_bank1;
  logic [7:0] priority_low_bank0;
  logic [7:0] priority_low_bank1;
  logic [7:0] priority_high_bank0;
  logic [7:0] priority_high_bank1;

  // per-source views in rank order
  // bit i of each view belongs to the source of rank i plus one
  logic [NS-1:0] src_raw;
  logic [NS-1:0] src_en;
  logic [NS-1:0] src_hi;
  logic [NS-1:0] src_lo;
  logic [NS-1:0] src_pend;
  logic [1:0]    src_lvl [NS];

  // arbitration result
  // valid, winning index, its level and whether it may be presented
  logic       win_valid;
  logic [3:0] win_idx;
  logic [1:0] win_lvl;
  logic       win_preempts;

  // nesting state
  logic [3:0] active_reg;
  logic [3:0] active_next;
  logic [1:0] top_lvl;
  logic [3:0] top_onehot;
  logic [3:0] set_onehot;
  logic       ack_taken;

  // read path
  logic [7:0] rd_next;

  // registered outputs
  logic        req_reg;
  logic        req_next;
  logic [15:0] vec_reg;
  logic [1:0]  lvl_reg;
  logic [7:0]  rdata_reg;

  // one storage byte per register, decoded from byte and bit ports
  // bit writes to the high priority bytes are refused; those bytes
  // take whole-byte writes only
  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_reg
      assign rif[g].wr_byte = reg_wr && (reg_addr == vip_pkg::REG_ADDR[g]);
      // bit address is the register base plus the bit number
      assign rif[g].bit_wr  = bit_wr && vip_pkg::REG_BIT_OK[g]
                              && (bit_addr[7:3] == vip_pkg::REG_ADDR[g][7:3]);
      assign rif[g].bit_idx = bit_addr[2:0];
      assign rif[g].bit_val = bit_wdata;
      assign rif[g].wdata   = reg_wdata;
      assign reg_q[g]       = rif[g].q;

      // reset to zero, reserved bits masked off
      vip_sfr_byte #(
        .WMASK (vip_pkg::REG_WMASK[g])
      ) u_byte (
        .clk (clk),
        .rst (rst),
        .rif (rif[g])
      );
    end
  endgenerate

  // name the bytes
  // indices are fixed, so a byte never moves between registers
  assign irq_enable_bank0 = reg_q[vip_pkg::IDX_IRQ_ENABLE_BANK0];
  assign irq_enable_bank1 = reg_q[vip_pkg::IDX_IRQ_ENABLE_BANK1];
  assign priority_low_bank0 = reg_q[vip_pkg::IDX_PRIORITY_LOW_BANK0];
  assign priority_low_bank1 = reg_q[vip_pkg::IDX_PRIORITY_LOW_BANK1];
  assign priority_high_bank0 = reg_q[vip_pkg::IDX_PRIORITY_HIGH_BANK0];
  assign priority_high_bank1 = reg_q[vip_pkg::IDX_PRIORITY_HIGH_BANK1];

  // spread two register banks into rank order
  // one mapping serves enables and both priority banks, since all
  // three share the same bit layout
  function automatic logic [NS-1:0] remap(input logic [7:0] b0,
                                          input logic [7:0] b1);
    logic [NS-1:0] r;
    r = '0;
    r[vip_pkg::SRC_EXT0]    = b0[vip_pkg::BIT_EXT0];
    r[vip_pkg::SRC_TIMER0]  = b0[vip_pkg::BIT_TIMER0];
    r[vip_pkg::SRC_EXT1]    = b0[vip_pkg::BIT_EXT1];
    r[vip_pkg::SRC_TIMER1]  = b0[vip_pkg::BIT_TIMER1];
    r[vip_pkg::SRC_PCA]     = b0[vip_pkg::BIT_PCA];
    r[vip_pkg::SRC_SERIAL]  = b0[vip_pkg::BIT_SERIAL];
    r[vip_pkg::SRC_TIMER2]  = b0[vip_pkg::BIT_TIMER2];
    r[vip_pkg::SRC_CAN]     = b1[vip_pkg::BIT_CAN];
    r[vip_pkg::SRC_ADC]     = b1[vip_pkg::BIT_ADC];
    r[vip_pkg::SRC_OVERRUN] = b1[vip_pkg::BIT_OVERRUN];
    r[vip_pkg::SRC_SPI]     = b1[vip_pkg::BIT_SPI];
    return r;
  endfunction

  // enables and both priority bits per source
  assign src_en = remap(irq_enable_bank0, irq_enable_bank1);
  assign src_lo = remap(priority_low_bank0, priority_low_bank1);
  assign src_hi = remap(priority_high_bank0, priority_high_bank1);

  // raw request lines in rank order
  // index equals polling rank minus one
  always_comb begin
    src_raw = '0;
    src_raw[vip_pkg::SRC_EXT0]    = external_request_0;
    src_raw[vip_pkg::SRC_TIMER0]  = timer0_req;
    src_raw[vip_pkg::SRC_EXT1]    = external_request_1;
    src_raw[vip_pkg::SRC_TIMER1]  = timer1_req;
    src_raw[vip_pkg::SRC_PCA]     = pca_req;
    src_raw[vip_pkg::SRC_SERIAL]  = serial_req;
    src_raw[vip_pkg::SRC_TIMER2]  = timer2_req;
    // any of the four controller events
    src_raw[vip_pkg::SRC_CAN]     = can_tx_done | can_rx_done
                                    | can_error | can_buf_overrun;
    // flag stays set until software clears it in the converter
    src_raw[vip_pkg::SRC_ADC]     = conversion_done_flag;
    src_raw[vip_pkg::SRC_OVERRUN] = can_timer_overflow;
    src_raw[vip_pkg::SRC_SPI]     = spi_req;
  end

  // pending: own enable and global enable both set
  // a masked source never reaches the arbiter, so it can neither
  // block nor delay any other source
  assign src_pend = src_raw & src_en
                    & {NS{irq_enable_bank0[vip_pkg::BIT_GLOBAL]}};

  // two-bit level from high and low bit
  // the pair compares as an unsigned two-bit number
  generate
    for (g = 0; g < NS; g++) begin : g_lvl
      assign src_lvl[g] = {src_hi[g], src_lo[g]};
    end
  endgenerate

  // highest level wins; lower rank kept on a tie
  // scanning from rank 1 upward and replacing only on a strictly higher
  // level leaves the first-ranked source of the top level in hand
  always_comb begin
    win_valid = 1'b0;
    win_idx   = 4'h0;
    win_lvl   = 2'b00;
    for (int i = 0; i < NS; i++) begin
      if (src_pend[i] && (!win_valid || src_lvl[i] > win_lvl)) begin
        win_valid = 1'b1;
        win_idx   = 4'(i);
        win_lvl   = src_lvl[i];
      end
    end
  end

  // highest level now in service
  // its one-hot form is what a return clears
  always_comb begin
    top_lvl    = 2'b00;
    top_onehot = 4'h0;
    for (int l = 0; l < vip_pkg::NUM_LVL; l++) begin
      if (active_reg[l]) begin
        top_lvl    = 2'(l);
        top_onehot = 4'h1 << l;
      end
    end
  end

  // a new request must beat the running handler strictly
  // level 3 in service leaves nothing above it, so all are held off
  assign win_preempts = win_valid
                        && ((active_reg == 4'h0)
                            || (win_lvl > top_lvl));

  // an acknowledge counts only while a request is presented
  assign ack_taken = irq_ack && req_reg;

  // level taken by the core this cycle
  assign set_onehot = ack_taken ? (4'h1 << lvl_reg) : 4'h0;

  // return drops the top level first, then a taken level is added
  // the taken level is ORed in after the clear, so it is never lost
  // when return and acknowledge fall in one cycle
  assign active_next = (active_reg & ~(irq_return ? top_onehot : 4'h0))
                       | set_onehot;

  // nesting state
  // bit l is set while a handler of level l runs; several may nest
  always_ff @(posedge clk) begin
    if (rst) begin
      active_reg <= 4'h0;
    end else begin
      active_reg <= active_next;
    end
  end

  // request withdrawn in the cycle the core takes it
  // a stray acknowledge while no request stands must not delay the
  // next request, so only a taken acknowledge withdraws it
  assign req_next = win_preempts && !ack_taken;

  // request, vector and level to the core
  // vector and level load only with a request, so they hold their
  // last value while the request is low
  always_ff @(posedge clk) begin
    if (rst) begin
      req_reg <= 1'b0;
      vec_reg <= 16'h0000;
      lvl_reg <= 2'b00;
    end else begin
      req_reg <= req_next;
      if (req_next) begin
        vec_reg <= vip_pkg::SRC_VECTOR[win_idx];
        lvl_reg <= win_lvl;
      end
    end
  end

  // read mux; unmapped addresses read zero
  // reserved bits are stored as zero, so they read back as zero
  always_comb begin
    rd_next = 8'h00;
    for (int r = 0; r < NR; r++) begin
      if (reg_addr == vip_pkg::REG_ADDR[r]) begin
        rd_next = reg_q[r];
      end
    end
    // status byte: levels in service, upper nibble zero
    if (reg_addr == vip_pkg::ADDR_IN_SERVICE) begin
      rd_next = {4'h0, active_reg};
    end
  end

  // read data stands in the cycle after the strobe only
  // forcing zero outside the read cycle keeps the bus quiet
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rd_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // outputs straight from flip-flops
  // the core sees only registered values, free of decode glitches
  assign reg_rdata  = rdata_reg;
  assign irq_req    = req_reg;
  assign irq_vector = vec_reg;
  assign irq_level  = lvl_reg;
  assign in_service = active_reg;

endmodule

`default_nettype wire

/* File: vip_prioritizer_sva.sv */
// checker for the vectored interrupt prioritizer, on its top-level ports.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module vip_prioritizer_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // core side
  input wire logic       irq_req,
  input wire logic [1:0] irq_level,
  input wire logic [3:0] in_service,
  input wire logic       irq_ack,
  input wire logic       irq_return
);
  logic [3:0] top_bit;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // highest level in service, one-hot
  assign top_bit = in_service[3] ? 4'h8 : in_service[2] ? 4'h4 :
                   in_service[1] ? 4'h2 : {3'h0, in_service[0]};

  a_read_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_reserved_read:
    assert property (reg_rd && reg_addr == 8'hE8 |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved enable bits read nonzero");
  a_status_read:
    assert property (reg_rd && reg_addr == 8'hF9
                     |=> reg_rdata == {4'h0, $past(in_service)})
    else $error("in-service read mismatch");
  a_global_off:
    assert property (reg_wr && reg_addr == 8'hA8 && !reg_wdata[7]
                     |=> ##1 !irq_req)
    else $error("request with global enable off");
  a_ack_drop:
    assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request stays after acknowledge");
  a_ack_level:
    assert property (irq_req && irq_ack |=> in_service[$past(irq_level)])
    else $error("acked level not in service");
  a_top_blocks:
    assert property (in_service[3] |-> !irq_req)
    else $error("request while top level in service");
  a_strict_higher:
    assert property (irq_req |-> (in_service >> irq_level) == 4'h0)
    else $error("request not above active level");
  a_return_top:
    assert property (irq_return && !irq_ack && in_service != 4'h0
                     |=> in_service == ($past(in_service) ^ $past(top_bit)))
    else $error("return did not clear top level");
endmodule

bind vip_prioritizer vip_prioritizer_sva u_sva (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_req(irq_req), .irq_level(irq_level), .in_service(in_service),
  .irq_ack(irq_ack), .irq_return(irq_return));

`default_nettype wire

/* File: vip_core_model.sv */
// processor core model: takes presented vectors with a set delay.
// assumes the bench drives take_en and ack_wait; return comes from bench.
`timescale 1ns/1ps
`default_nettype none

module vip_core_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // behaviour chosen by the bench
  input  wire logic       take_en,
  input  wire logic [3:0] ack_wait,
  // prioritizer side
  input  wire logic       irq_req,
  output logic            irq_ack
);
  logic [3:0] wait_reg;

  // one-cycle acknowledge after ack_wait cycles of a standing request
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_reg <= 4'h0;
      irq_ack  <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      if (irq_req && take_en && !irq_ack) begin
        if (wait_reg == ack_wait) begin
          irq_ack  <= 1'b1;
          wait_reg <= 4'h0;
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end else begin
        wait_reg <= 4'h0;
      end
    end
  end
endmodule

`default_nettype wire

/* File: vectored_interrupt_prioritizer_test.sv */
// self-checking bench: table of request cases, then reset, registers
// and nesting. assumes vip_pkg, core model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none

module vectored_interrupt_prioritizer_test;
  typedef struct {
    logic [47:0] cfg; // enable 0, low 0, high 0, enable 1, low 1, high 1
    logic [13:0] src;
    logic        req;
    logic [15:0] vec;
    logic [1:0]  lvl;
  } vip_row_t;

  localparam logic [47:0] BASE = 48'hFF00_000F_0000;

  logic        clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        bit_wr;
  logic [7:0]  bit_addr;
  logic        bit_wdata;
  logic [13:0] src;
  logic        irq_req;
  logic [15:0] irq_vector;
  logic [1:0]  irq_level;
  logic [3:0]  in_service;
  logic        irq_ack;
  logic        irq_return;
  logic        take_en;
  logic [3:0]  ack_wait;
  int          failures;
  int          n_compared;

  // cases: configuration, sources, expected request, vector, level
  vip_row_t rows [24] = '{
    '{BASE, 14'h0001, 1'h1, 16'h0003, 2'h0},
    '{BASE, 14'h0002, 1'h1, 16'h000B, 2'h0},
    '{BASE, 14'h0004, 1'h1, 16'h0013, 2'h0},
    '{BASE, 14'h0008, 1'h1, 16'h001B, 2'h0},
    '{BASE, 14'h0010, 1'h1, 16'h0033, 2'h0},
    '{BASE, 14'h0020, 1'h1, 16'h0023, 2'h0},
    '{BASE, 14'h0040, 1'h1, 16'h002B, 2'h0},
    '{BASE, 14'h0080, 1'h1, 16'h003B, 2'h0},
    '{BASE, 14'h0100, 1'h1, 16'h0043, 2'h0},
    '{BASE, 14'h0200, 1'h1, 16'h004B, 2'h0},
    '{BASE, 14'h0400, 1'h1, 16'h0053, 2'h0},
    '{BASE, 14'h0800, 1'h1, 16'h003B, 2'h0},
    '{BASE, 14'h1000, 1'h1, 16'h003B, 2'h0},
    '{BASE, 14'h2000, 1'h1, 16'h003B, 2'h0},
    '{BASE, 14'h3FFF, 1'h1, 16'h0003, 2'h0},
    '{BASE, 14'h0030, 1'h1, 16'h0033, 2'h0},
    '{BASE, 14'h0760, 1'h1, 16'h0023, 2'h0},
    '{48'h7F00_000F_0000, 14'h3FFF, 1'h0, 16'h0000, 2'h0},
    '{48'hFE00_000F_0000, 14'h0003, 1'h1, 16'h000B, 2'h0},
    '{48'hFF00_000E_0000, 14'h0480, 1'h1, 16'h0053, 2'h0},
    '{48'hFF00_000D_0000, 14'h0100, 1'h0, 16'h0000, 2'h0},
    '{48'hFF00_000F_0808, 14'h0401, 1'h1, 16'h0053, 2'h3},
    '{48'hFF01_020F_0200, 14'h0183, 1'h1, 16'h000B, 2'h2},
    '{48'hFF40_420F_0004, 14'h0212, 1'h1, 16'h0033, 2'h3}
  };

  vip_prioritizer DUT (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_wdata(bit_wdata),
    .external_request_0(src[0]), .timer0_req(src[1]),
    .external_request_1(src[2]), .timer1_req(src[3]), .pca_req(src[4]),
    .serial_req(src[5]), .timer2_req(src[6]), .can_tx_done(src[7]),
    .conversion_done_flag(src[8]), .can_timer_overflow(src[9]),
    .spi_req(src[10]), .can_rx_done(src[11]), .can_error(src[12]),
    .can_buf_overrun(src[13]), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level),
    .in_service(in_service), .irq_ack(irq_ack), .irq_return(irq_return));

  vip_core_model u_core (
    .clk(clk), .rst(rst), .take_en(take_en), .ack_wait(ack_wait),
    .irq_req(irq_req), .irq_ack(irq_ack));

  // 25 ns clock
  always #12.5 clk = ~clk;

  task automatic chk(input logic [15:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge clk);
    bit_addr  <= a;
    bit_wdata <= v;
    bit_wr    <= 1'b1;
    @(posedge clk);
    bit_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(exp), "read");
  endtask

  task automatic set_cfg(input logic [47:0] c);
    for (int k = 0; k < 6; k++) begin
      wr(vip_pkg::REG_ADDR[k], c[47-8*k -: 8]);
    end
  endtask

  task automatic put_src(input logic [13:0] v);
    @(posedge clk);
    src <= v;
  endtask

  task automatic ret();
    @(posedge clk);
    irq_return <= 1'b1;
    @(posedge clk);
    irq_return <= 1'b0;
    #1;
  endtask

  task automatic wait_req();
    for (int i = 0; i < 20 && irq_req !== 1'b1; i++) cyc(1);
  endtask

  task automatic wait_svc(input logic [3:0] exp);
    for (int i = 0; i < 20 && in_service !== exp; i++) cyc(1);
    chk(16'(in_service), 16'(exp), "in service");
  endtask

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    test_done();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {bit_wr, bit_addr, bit_wdata, src, irq_return} = '0;
    {take_en, ack_wait, failures, n_compared} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      set_cfg(rows[i].cfg);
      put_src(rows[i].src);
      cyc(3);
      chk(16'(irq_req), 16'(rows[i].req), "request");
      if (rows[i].req) begin
        chk(irq_vector, rows[i].vec, "vector");
        chk(16'(irq_level), 16'(rows[i].lvl), "level");
      end
      put_src(14'h0000);
    end
    $display("test table finished");
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk(16'(irq_req), 16'h0000, "request after reset");
    for (int k = 0; k < 6; k++) rd(vip_pkg::REG_ADDR[k], 8'h00);
    $display("test reset finished");
    wr(8'hE8, 8'h0F);
    rd(8'hE8, 8'h0F);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 8'h7F);
    wr(8'hB7, 8'hFF);
    rd(8'hB7, 8'h7F);
    wr(8'hF7, 8'hFF);
    rd(8'hF7, 8'h0F);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    wr(8'hA8, 8'h00);
    bw(8'hAF, 1'b1);
    bw(8'hAB, 1'b1);
    rd(8'hA8, 8'h88);
    bw(8'hAF, 1'b0);
    rd(8'hA8, 8'h08);
    bw(8'hE9, 1'b0);
    rd(8'hE8, 8'h0D);
    bw(8'hFB, 1'b1);
    rd(8'hF8, 8'h08);
    $display("test registers finished");
    set_cfg(48'hFF04_040F_0008);
    take_en <= 1'b1;
    ack_wait <= 4'h5;
    put_src(14'h0008);
    wait_req();
    chk(irq_vector, 16'h001B, "vector");
    wait_svc(4'h1);
    put_src(14'h0001);
    cyc(4);
    chk(16'(irq_req), 16'h0000, "equal level");
    ack_wait <= 4'h2;
    put_src(14'h0005);
    wait_req();
    chk(irq_vector, 16'h0013, "vector");
    wait_svc(4'h9);
    rd(8'hF9, 8'h09);
    put_src(14'h0401);
    cyc(4);
    chk(16'(irq_req), 16'h0000, "top level");
    ret();
    wait_req();
    chk(irq_vector, 16'h0053, "vector");
    wait_svc(4'h5);
    put_src(14'h0001);
    ret();
    cyc(3);
    chk(16'(irq_req), 16'h0000, "equal level");
    ret();
    wait_req();
    chk(irq_vector, 16'h0003, "vector");
    wait_svc(4'h1);
    put_src(14'h0000);
    ret();
    wait_svc(4'h0);
    $display("test nesting finished");
    test_done();
  end
endmodule

`default_nettype wire
